// ==== include/hcr_consts.vh ====
`ifndef HCR_CONSTS_VH
`define HCR_CONSTS_VH

// ==========================================================
// Word addresses (byte offset)
`define HCR_OFS_CSR_BASE    8'h50
`define HCR_OFS_ID          8'h50
`define HCR_OFS_IRQ_CFG     8'h54
`define HCR_OFS_INTERRUPT_STATUS     8'h58
`define HCR_OFS_INT_EN      8'h5c
`define HCR_OFS_RSVD_A      8'h60
`define HCR_OFS_BYTE_TEST   8'h64
`define HCR_OFS_FIFO_LVL    8'h68
`define HCR_OFS_RX_CFG      8'h6c
`define HCR_OFS_TX_CFG      8'h70
`define HCR_OFS_HARDWARE_CONFIG      8'h74
`define HCR_OFS_RX_PATH     8'h78
`define HCR_OFS_RX_LVL      8'h7c
`define HCR_OFS_TX_LVL      8'h80
`define HCR_OFS_PMT         8'h84
`define HCR_OFS_GPIO        8'h88
`define HCR_OFS_TIMER_CONFIG     8'h8c
`define HCR_OFS_TIMER_COUNT     8'h90
`define HCR_OFS_RSVD_B      8'h94
`define HCR_OFS_SWAP        8'h98
`define HCR_OFS_FREE_RUN    8'h9c
`define HCR_OFS_RX_DROP     8'ha0
`define HCR_OFS_MAC_CMD     8'ha4
`define HCR_OFS_MAC_DATA    8'ha8
`define HCR_OFS_AFC         8'hac
`define HCR_OFS_ROM_CMD     8'hb0
`define HCR_OFS_ROM_DATA    8'hb4
`define HCR_OFS_RSVD_LO     8'hb8

// Queue ports below the register region
`define HCR_OFS_RXD_LO      8'h00
`define HCR_OFS_TXD_LO      8'h20
`define HCR_OFS_RXS_POP     8'h40
`define HCR_OFS_RXS_NONDESTRUCTIVE_VIEW    8'h44
`define HCR_OFS_TXS_POP     8'h48
`define HCR_OFS_TXS_NONDESTRUCTIVE_VIEW    8'h4c

// ==========================================================
// Reset values
`define HCR_RST_ZERO        32'h0000_0000
`define HCR_RST_BYTE_TEST   32'h8765_4321
`define HCR_RST_FIFO_LVL    32'h4800_0000
`define HCR_RST_HARDWARE_CONFIG      32'h0005_0000
`define HCR_RST_TX_LVL      32'h0000_1200
`define HCR_RST_GPT         32'h0000_ffff

// ==========================================================
// Field positions
`define HCR_IRQ_TYPE_BIT    0
`define HCR_IRQ_POL_BIT     4
`define HCR_IRQ_EN_BIT      8
`define HCR_IRQ_INT_BIT     12
`define HCR_HW_SRST_BIT     0
`define HCR_INT_LINK_BIT    0

// Writable masks
`define HCR_IRQ_CFG_WMASK   32'hff00_0111
`define HCR_IRQ_SOFT_RESET_IMMUNE_MASK   32'h0000_0011
`define HCR_HARDWARE_CONFIG_WMASK    32'hffff_fffe

`endif

// ==== rtl/hcr_csr_map.v ====
// ==========================================================
// Functional notes
// - Latching status bits hold their capture until the register is read, then clear.
// - Soft-reset-immune fields keep their value across a software reset.
// - Host writes zeros to reserved bits; reserved bits read back undefined.
// - Reserved locations 60h, 94h, B8h-FCh return an arbitrary value.
// - Hard resets load all configuration registers with defaults; soft reset keeps the immune IRQ_CFG bits.
// - Four host queues exist: rx status, rx data, tx status, tx data.
// - Rx status port read returns the oldest entry and pops it.
// - Rx status view read returns the oldest entry without popping.
// - Rx data is destructive only, mirrored at 8 words, each pops.
// - Tx status port read returns the oldest entry and pops it.
// - Tx status view read returns the oldest entry, queue unchanged.
// - Tx data is write only; all 8 mirrored words push identically.
// - Registers decode directly at 50h to FCh in 4-byte steps.
// - Endian test register at 64h is read-only, returns 87654321h.
// - MAC registers reached via command at A4h and data at A8h.
// - Serial ROM reached via command at B0h and data at B4h.
// - Timer config 8Ch and timer count 90h reset to 0000FFFFh.
// - Rx drop counter at A0h resets to zero and is readable.
// - Writes to read-only registers do nothing; write-only reads return zero.
// - Write-one-to-clear bits clear on one, keep on zero.
// - Host transfers 16-bit halves of each 32-bit word.
`timescale 1ns/10ps
`include "hcr_consts.vh"

module hcr_csr_map #(
	parameter [15:0] CHIP_ID  = 16'h0a5a,	// Arbitrary identity value
	parameter [15:0] CHIP_REV = 16'h0003	// Arbitrary identity value
) (
	input  wire        I_CLK,
	input  wire        I_RST_N,
	input  wire        I_POR_N,
	input  wire        I_RD,
	input  wire        I_WR,
	input  wire [7:1]  I_ADDR,
	input  wire [15:0] I_WDATA,
	output reg  [15:0] O_RDATA,
	output reg         O_RDATA_VALID,
	input  wire [31:0] I_RXS_DATA,
	input  wire        I_RXS_VALID,
	output reg         O_RXS_POP,
	input  wire [31:0] I_RXD_DATA,
	output reg         O_RXD_POP,
	input  wire [31:0] I_TXS_DATA,
	input  wire        I_TXS_VALID,
	output reg         O_TXS_POP,
	output reg  [31:0] O_TXD_DATA,
	output reg         O_TXD_PUSH,
	input  wire [31:0] I_INT_EVENTS,
	input  wire        I_LINK_DOWN,
	input  wire [31:0] I_RX_LEVELS,
	input  wire [31:0] I_TX_LEVELS,
	input  wire        I_RX_DROP_INC,
	input  wire [31:0] I_MAC_RDATA,
	input  wire [31:0] I_ROM_RDATA,
	output reg  [31:0] O_MAC_CMD,
	output reg  [31:0] O_MAC_WDATA,
	output reg         O_MAC_CMD_WR,
	output reg  [31:0] O_ROM_CMD,
	output reg  [31:0] O_ROM_WDATA,
	output reg         O_ROM_CMD_WR,
	output reg  [31:0] O_RX_CFG,
	output reg  [31:0] O_TX_CFG,
	output reg  [31:0] O_HARDWARE_CONFIG,
	output reg  [31:0] O_IRQ_CFG,
	output reg  [31:0] O_INT_EN,
	output reg  [31:0] O_FIFO_LVL,
	output reg  [31:0] O_GPIO_CFG,
	output reg  [31:0] O_TIMER_CONFIG,
	output reg  [31:0] O_FLOW_CONTROL_CONFIG,
	output reg  [31:0] O_POWER_MGMT_CONTROL,
	output reg  [31:0] O_SWAP
);

// ==========================================================
// Address classes
function is_rsvd;
	input [7:0] a;
	begin
		is_rsvd = (a == `HCR_OFS_RSVD_A) || (a == `HCR_OFS_RSVD_B) ||
			(a >= `HCR_OFS_RSVD_LO);
	end
endfunction

function [31:0] merge_wr;
	input [31:0] old;
	input [31:0] val;
	input [31:0] mask;
	begin
		merge_wr = (old & ~mask) | (val & mask);
	end
endfunction

// ==========================================================
// Half-word pairing
// Low half arrives first and is held; the high half commits the word.
reg  [15:0] wr_lo_reg;
reg  [15:0] rd_hi_reg;
reg  [31:0] interrupt_status_reg;
reg  [31:0] timer_count_reg;
reg  [31:0] free_run_reg;
reg  [31:0] rx_drop_reg;
reg         link_latch_reg;
reg         srst_req_reg;
reg         wr_lo_seen_reg;
reg  [7:0]  wr_lo_addr_reg;
reg         rd_lo_seen_reg;
reg  [7:0]  rd_lo_addr_reg;

wire [7:0]  word_addr = {I_ADDR, 1'b0} & 8'hfc;
wire        hi_half   = I_ADDR[1];
wire [31:0] wr_word   = {I_WDATA, wr_lo_reg};
wire        wr_commit = I_WR & hi_half & wr_lo_seen_reg &
	(wr_lo_addr_reg == word_addr);
wire        rd_commit = I_RD & hi_half & rd_lo_seen_reg &
	(rd_lo_addr_reg == word_addr);
wire        soft_rst  = srst_req_reg;
wire        any_rst   = ~I_RST_N | ~I_POR_N | soft_rst;

// ==========================================================
// Read mux
reg [31:0] rd_word;
always @* begin
	rd_word = `HCR_RST_ZERO;
	if (word_addr < `HCR_OFS_TXD_LO)
		rd_word = I_RXD_DATA;
	else if (word_addr < `HCR_OFS_RXS_POP)
		rd_word = `HCR_RST_ZERO;
	else if (word_addr == `HCR_OFS_RXS_POP || word_addr == `HCR_OFS_RXS_NONDESTRUCTIVE_VIEW)
		rd_word = I_RXS_DATA;
	else if (word_addr == `HCR_OFS_TXS_POP || word_addr == `HCR_OFS_TXS_NONDESTRUCTIVE_VIEW)
		rd_word = I_TXS_DATA;
	else if (is_rsvd(word_addr))
		rd_word = free_run_reg;
	else begin
		case (word_addr)
		`HCR_OFS_ID:        rd_word = {CHIP_ID, CHIP_REV};
		`HCR_OFS_IRQ_CFG:   rd_word = O_IRQ_CFG |
			({31'h0, |(interrupt_status_reg & O_INT_EN)} << `HCR_IRQ_INT_BIT);
		`HCR_OFS_INTERRUPT_STATUS:   rd_word = interrupt_status_reg;
		`HCR_OFS_INT_EN:    rd_word = O_INT_EN;
		`HCR_OFS_BYTE_TEST: rd_word = `HCR_RST_BYTE_TEST;
		`HCR_OFS_FIFO_LVL:  rd_word = O_FIFO_LVL;
		`HCR_OFS_RX_CFG:    rd_word = O_RX_CFG;
		`HCR_OFS_TX_CFG:    rd_word = O_TX_CFG;
		`HCR_OFS_HARDWARE_CONFIG:    rd_word = O_HARDWARE_CONFIG;
		`HCR_OFS_RX_PATH:   rd_word = `HCR_RST_ZERO;
		`HCR_OFS_RX_LVL:    rd_word = I_RX_LEVELS;
		`HCR_OFS_TX_LVL:    rd_word = I_TX_LEVELS;
		`HCR_OFS_PMT:       rd_word = (O_POWER_MGMT_CONTROL & ~(32'h1 << `HCR_INT_LINK_BIT)) |
			({31'h0, link_latch_reg} << `HCR_INT_LINK_BIT);
		`HCR_OFS_GPIO:      rd_word = O_GPIO_CFG;
		`HCR_OFS_TIMER_CONFIG:   rd_word = O_TIMER_CONFIG;
		`HCR_OFS_TIMER_COUNT:   rd_word = timer_count_reg;
		`HCR_OFS_SWAP:      rd_word = O_SWAP;
		`HCR_OFS_FREE_RUN:  rd_word = free_run_reg;
		`HCR_OFS_RX_DROP:   rd_word = rx_drop_reg;
		`HCR_OFS_MAC_CMD:   rd_word = O_MAC_CMD;
		`HCR_OFS_MAC_DATA:  rd_word = I_MAC_RDATA;
		`HCR_OFS_AFC:       rd_word = O_FLOW_CONTROL_CONFIG;
		`HCR_OFS_ROM_CMD:   rd_word = O_ROM_CMD;
		`HCR_OFS_ROM_DATA:  rd_word = I_ROM_RDATA;
		default:            rd_word = `HCR_RST_ZERO;
		endcase
	end
end

// ==========================================================
// Bus side: data return and pairing state
always @(posedge I_CLK) begin
	if (!I_RST_N || !I_POR_N) begin
		wr_lo_reg      <= 16'h0000;
		rd_hi_reg      <= 16'h0000;
		O_RDATA        <= 16'h0000;
		O_RDATA_VALID  <= 1'b0;
		wr_lo_seen_reg <= 1'b0;
		wr_lo_addr_reg <= 8'h00;
		rd_lo_seen_reg <= 1'b0;
		rd_lo_addr_reg <= 8'h00;
	end else begin
		O_RDATA_VALID <= I_RD;
		if (I_WR && !hi_half)
			wr_lo_reg <= I_WDATA;
		// Any half restarts pairing, so a lone high half never commits stale data
		if (I_WR) begin
			wr_lo_seen_reg <= !hi_half;
			wr_lo_addr_reg <= word_addr;
		end
		if (I_RD) begin
			rd_lo_seen_reg <= !hi_half;
			rd_lo_addr_reg <= word_addr;
		end
		// High half comes from the snapshot so the pair reads one word
		if (I_RD && !hi_half) begin
			O_RDATA   <= rd_word[15:0];
			rd_hi_reg <= rd_word[31:16];
		end else if (I_RD) begin
			O_RDATA <= rd_hi_reg;
		end
	end
end

// ==========================================================
// Queue strobes
always @(posedge I_CLK) begin
	if (!I_RST_N || !I_POR_N) begin
		O_RXS_POP  <= 1'b0;
		O_RXD_POP  <= 1'b0;
		O_TXS_POP  <= 1'b0;
		O_TXD_PUSH <= 1'b0;
		O_TXD_DATA <= `HCR_RST_ZERO;
	end else begin
		O_RXS_POP  <= rd_commit && word_addr == `HCR_OFS_RXS_POP && I_RXS_VALID;
		O_TXS_POP  <= rd_commit && word_addr == `HCR_OFS_TXS_POP && I_TXS_VALID;
		O_RXD_POP  <= rd_commit && word_addr < `HCR_OFS_TXD_LO;
		O_TXD_PUSH <= wr_commit && word_addr >= `HCR_OFS_TXD_LO &&
			word_addr < `HCR_OFS_RXS_POP;
		if (wr_commit && word_addr >= `HCR_OFS_TXD_LO && word_addr < `HCR_OFS_RXS_POP)
			O_TXD_DATA <= wr_word;
	end
end

// ==========================================================
// Soft-reset-immune fields: only hard resets touch them
always @(posedge I_CLK) begin
	if (!I_RST_N || !I_POR_N) begin
		O_IRQ_CFG <= `HCR_RST_ZERO;
	end else if (soft_rst) begin
		O_IRQ_CFG <= O_IRQ_CFG & `HCR_IRQ_SOFT_RESET_IMMUNE_MASK;
	end else if (wr_commit && word_addr == `HCR_OFS_IRQ_CFG) begin
		O_IRQ_CFG <= merge_wr(O_IRQ_CFG, wr_word, `HCR_IRQ_CFG_WMASK);
	end
end

// ==========================================================
// Configuration and status registers
always @(posedge I_CLK) begin
	if (any_rst) begin
		O_INT_EN       <= `HCR_RST_ZERO;
		O_FIFO_LVL     <= `HCR_RST_FIFO_LVL;
		O_RX_CFG       <= `HCR_RST_ZERO;
		O_TX_CFG       <= `HCR_RST_ZERO;
		O_HARDWARE_CONFIG       <= `HCR_RST_HARDWARE_CONFIG;
		O_POWER_MGMT_CONTROL     <= `HCR_RST_ZERO;
		O_GPIO_CFG     <= `HCR_RST_ZERO;
		O_TIMER_CONFIG      <= `HCR_RST_GPT;
		O_SWAP         <= `HCR_RST_ZERO;
		O_FLOW_CONTROL_CONFIG      <= `HCR_RST_ZERO;
		O_MAC_CMD      <= `HCR_RST_ZERO;
		O_MAC_WDATA    <= `HCR_RST_ZERO;
		O_ROM_CMD      <= `HCR_RST_ZERO;
		O_ROM_WDATA    <= `HCR_RST_ZERO;
		O_MAC_CMD_WR   <= 1'b0;
		O_ROM_CMD_WR   <= 1'b0;
		interrupt_status_reg    <= `HCR_RST_ZERO;
		timer_count_reg    <= `HCR_RST_GPT;
		rx_drop_reg    <= `HCR_RST_ZERO;
		link_latch_reg <= 1'b0;
		srst_req_reg   <= 1'b0;
	end else begin
		O_MAC_CMD_WR <= wr_commit && word_addr == `HCR_OFS_MAC_CMD;
		O_ROM_CMD_WR <= wr_commit && word_addr == `HCR_OFS_ROM_CMD;
		// Self-clearing soft reset request; takes effect next cycle
		srst_req_reg <= wr_commit && word_addr == `HCR_OFS_HARDWARE_CONFIG &&
			wr_word[`HCR_HW_SRST_BIT];
		if (wr_commit && !is_rsvd(word_addr)) begin
			case (word_addr)
			`HCR_OFS_INT_EN:   O_INT_EN    <= wr_word;
			`HCR_OFS_FIFO_LVL: O_FIFO_LVL  <= wr_word;
			`HCR_OFS_RX_CFG:   O_RX_CFG    <= wr_word;
			`HCR_OFS_TX_CFG:   O_TX_CFG    <= wr_word;
			`HCR_OFS_HARDWARE_CONFIG:   O_HARDWARE_CONFIG    <= merge_wr(O_HARDWARE_CONFIG, wr_word,
				`HCR_HARDWARE_CONFIG_WMASK);
			`HCR_OFS_PMT:      O_POWER_MGMT_CONTROL  <= wr_word;
			`HCR_OFS_GPIO:     O_GPIO_CFG  <= wr_word;
			`HCR_OFS_TIMER_CONFIG:  O_TIMER_CONFIG   <= wr_word;
			`HCR_OFS_SWAP:     O_SWAP      <= wr_word;
			`HCR_OFS_AFC:      O_FLOW_CONTROL_CONFIG   <= wr_word;
			`HCR_OFS_MAC_CMD:  O_MAC_CMD   <= wr_word;
			`HCR_OFS_MAC_DATA: O_MAC_WDATA <= wr_word;
			`HCR_OFS_ROM_CMD:  O_ROM_CMD   <= wr_word;
			`HCR_OFS_ROM_DATA: O_ROM_WDATA <= wr_word;
			default:           O_INT_EN    <= O_INT_EN;
			endcase
		end
		// Events set, host one clears; a set in the same cycle wins
		if (wr_commit && word_addr == `HCR_OFS_INTERRUPT_STATUS)
			interrupt_status_reg <= (interrupt_status_reg & ~wr_word) | I_INT_EVENTS;
		else
			interrupt_status_reg <= interrupt_status_reg | I_INT_EVENTS;
		// Latch-high of link loss; read clears unless a new event lands
		if (I_LINK_DOWN)
			link_latch_reg <= 1'b1;
		else if (rd_commit && word_addr == `HCR_OFS_PMT)
			link_latch_reg <= 1'b0;
		// Timer reloads when the config is written or the count reaches zero, else counts down
		if (wr_commit && word_addr == `HCR_OFS_TIMER_CONFIG)
			timer_count_reg <= {16'h0000, wr_word[15:0]};
		else if (timer_count_reg == `HCR_RST_ZERO)
			timer_count_reg <= {16'h0000, O_TIMER_CONFIG[15:0]};
		else
			timer_count_reg <= timer_count_reg - 32'h1;
		if (I_RX_DROP_INC)
			rx_drop_reg <= rx_drop_reg + 32'h1;
		else if (rd_commit && word_addr == `HCR_OFS_RX_DROP)
			rx_drop_reg <= `HCR_RST_ZERO;
	end
end

// ==========================================================
// Free-running counter; not cleared by soft reset
always @(posedge I_CLK) begin
	if (!I_RST_N || !I_POR_N)
		free_run_reg <= `HCR_RST_ZERO;
	else
		free_run_reg <= free_run_reg + 32'h1;
end

endmodule

// ==== verif/hcr_csr_map_chk.sv ====
`timescale 1ns/10ps
module hcr_csr_map_chk (
	input wire        I_CLK,
	input wire        I_RST_N,
	input wire        I_RD,
	input wire        I_WR,
	input wire [7:1]  I_ADDR,
	input wire [15:0] I_WDATA,
	input wire [15:0] O_RDATA,
	input wire        O_RDATA_VALID,
	input wire        I_RXS_VALID,
	input wire        I_TXS_VALID,
	input wire        O_RXS_POP,
	input wire        O_RXD_POP,
	input wire        O_TXS_POP,
	input wire        O_TXD_PUSH,
	input wire [31:0] O_TXD_DATA,
	input wire [31:0] O_TIMER_CONFIG
);
	wire [7:0] byte_addr = {I_ADDR, 1'b0};
	default clocking chk_cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// ====================================
	// Assertions
	a_read_answers: assert property (I_RD |=> O_RDATA_VALID)
		else $error("read not answered");
	a_valid_cause: assert property (O_RDATA_VALID |-> $past(I_RD))
		else $error("read answer without read");
	a_endian_fixed: assert property (I_RD && byte_addr[7:2] == 6'h19 |=>
		O_RDATA == ($past(I_ADDR[1]) ? 16'h8765 : 16'h4321)) else $error("endian pattern wrong");
	a_rxs_pop_high: assert property (I_RD && byte_addr == 8'h42 && I_RXS_VALID &&
		$past(I_RD) && $past(I_ADDR) == 7'h20 |=> O_RXS_POP)
		else $error("rx status not popped");
	a_rxs_pop_gated: assert property (O_RXS_POP |-> $past(I_RXS_VALID && I_RD))
		else $error("rx status popped without cause");
	a_txs_pop_high: assert property (I_RD && byte_addr == 8'h4a && I_TXS_VALID &&
		$past(I_RD) && $past(I_ADDR) == 7'h24 |=> O_TXS_POP)
		else $error("tx status not popped");
	a_rx_view_keeps: assert property (I_RD && byte_addr[7:2] == 6'h11 |=> !O_RXS_POP)
		else $error("rx view popped");
	a_tx_view_keeps: assert property (I_RD && byte_addr[7:2] == 6'h13 |=> !O_TXS_POP)
		else $error("tx view popped");
	a_rxd_alias_pop: assert property (I_RD && I_ADDR[1] && I_ADDR[7:5] == 3'b000 &&
		$past(I_RD) && $past(I_ADDR) == {I_ADDR[7:2], 1'b0} |=> O_RXD_POP)
		else $error("rx data alias not popped");
	a_rxd_pop_cause: assert property (O_RXD_POP |->
		$past(I_RD && I_ADDR[1] && I_ADDR[7:5] == 3'b000))
		else $error("rx data popped without high half");
	a_txd_alias_push: assert property (I_WR && I_ADDR[1] && I_ADDR[7:5] == 3'b001 &&
		$past(I_WR) && $past(I_ADDR) == {I_ADDR[7:2], 1'b0} |=>
		O_TXD_PUSH && O_TXD_DATA == {$past(I_WDATA), $past(I_WDATA, 2)})
		else $error("tx data push wrong");
	a_push_high_only: assert property (O_TXD_PUSH |-> $past(I_WR && I_ADDR[1]))
		else $error("push before high half");
	a_timer_default: assert property ($rose(I_RST_N) |-> O_TIMER_CONFIG == 32'h0000_ffff)
		else $error("timer config default wrong");
	c_rxs_pop: cover property (O_RXS_POP);
	c_txs_pop: cover property (O_TXS_POP);
	c_rxd_pop: cover property (O_RXD_POP);
	c_txd_push: cover property (O_TXD_PUSH);
endmodule

bind hcr_csr_map hcr_csr_map_chk u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_RD(I_RD), .I_WR(I_WR),
	.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_RDATA_VALID(O_RDATA_VALID),
	.I_RXS_VALID(I_RXS_VALID), .I_TXS_VALID(I_TXS_VALID), .O_RXS_POP(O_RXS_POP),
	.O_RXD_POP(O_RXD_POP), .O_TXS_POP(O_TXS_POP), .O_TXD_PUSH(O_TXD_PUSH),
	.O_TXD_DATA(O_TXD_DATA), .O_TIMER_CONFIG(O_TIMER_CONFIG));

// ==== verif/hcr_queue_model.sv ====
`timescale 1ns/10ps
module hcr_queue_model (
	input  wire        i_clk,
	input  wire        i_rxs_pop,
	input  wire        i_rxd_pop,
	input  wire        i_txs_pop,
	input  wire        i_txd_push,
	input  wire [31:0] i_txd_data,
	output wire [31:0] o_rxs_data,
	output wire        o_rxs_valid,
	output wire [31:0] o_rxd_data,
	output wire [31:0] o_txs_data,
	output wire        o_txs_valid
);
	logic [31:0] rxs_ptr = 0;
	logic [31:0] rxd_ptr = 0;
	logic [31:0] txs_ptr = 0;
	logic [31:0] txd_cnt = 0;
	logic [31:0] txd_log [0:7];
	// ====================================
	// Two status entries each; an empty head shows inverted stale data
	assign o_rxs_valid = rxs_ptr < 2;
	assign o_txs_valid = txs_ptr < 2;
	assign o_rxs_data = o_rxs_valid ? 32'ha500_0000 + rxs_ptr : ~(32'ha4ff_ffff + rxs_ptr);
	assign o_txs_data = o_txs_valid ? 32'hc300_0000 + txs_ptr : ~(32'hc2ff_ffff + txs_ptr);
	assign o_rxd_data = 32'hd000_0000 + rxd_ptr;
	always @(posedge i_clk) begin
		if (i_rxs_pop) rxs_ptr <= rxs_ptr + 1;
		if (i_txs_pop) txs_ptr <= txs_ptr + 1;
		if (i_rxd_pop) rxd_ptr <= rxd_ptr + 1;
		if (i_txd_push) begin
			txd_log[txd_cnt[2:0]] <= i_txd_data;
			txd_cnt <= txd_cnt + 1;
		end
	end
endmodule

// ==== verif/tb_host_csr_map_and_fifo_ports.sv ====
`timescale 1ns/10ps
module tb_host_csr_map_and_fifo_ports;
	logic        clk = 0;
	logic        rst_n = 0;
	logic        rd = 0;
	logic        wr = 0;
	logic [7:1]  addr = 0;
	logic [15:0] wdata = 0;
	logic [31:0] int_ev = 0;
	logic        drop_inc = 0;
	logic        link_dn = 0;
	logic [31:0] mac_rd = 32'h1357_9bdf;
	logic [31:0] rom_rd = 32'h2468_ace0;
	logic [31:0] d, e;
	logic [7:0]  b;
	wire  [15:0] rdata;
	wire         rxs_pop, rxd_pop, txs_pop, txd_push, rxs_v, txs_v, mac_wr, rom_wr;
	wire  [31:0] rxs_d, rxd_d, txs_d, txd_d, mac_cmd, rom_cmd;
	wire  [31:0] mac_wd, rom_wd, irq_cfg, hardware_config, int_en;
	int          miscompares = 0;
	int          tests_run = 0;
	int          cycles = 0;
	logic [39:0] rst_tab [0:13] = '{{8'h54, 32'h0}, {8'h58, 32'h0}, {8'h5c, 32'h0},
		{8'h64, 32'h8765_4321}, {8'h68, 32'h4800_0000}, {8'h6c, 32'h0}, {8'h70, 32'h0},
		{8'h74, 32'h0005_0000}, {8'h7c, 32'h0000_0a0b}, {8'h88, 32'h0}, {8'h8c, 32'h0000_ffff},
		{8'h98, 32'h0}, {8'ha0, 32'h0}, {8'hac, 32'h0}};
	always #5 clk = ~clk;
	hcr_csr_map dut (
		.I_CLK(clk), .I_RST_N(rst_n), .I_POR_N(1'b1), .I_RD(rd), .I_WR(wr), .I_ADDR(addr),
		.I_WDATA(wdata), .O_RDATA(rdata), .O_RDATA_VALID(), .I_RXS_DATA(rxs_d),
		.I_RXS_VALID(rxs_v), .O_RXS_POP(rxs_pop), .I_RXD_DATA(rxd_d), .O_RXD_POP(rxd_pop),
		.I_TXS_DATA(txs_d), .I_TXS_VALID(txs_v), .O_TXS_POP(txs_pop), .O_TXD_DATA(txd_d),
		.O_TXD_PUSH(txd_push), .I_INT_EVENTS(int_ev), .I_LINK_DOWN(link_dn),
		.I_RX_LEVELS(32'h0000_0a0b), .I_TX_LEVELS(32'h0000_1200), .I_RX_DROP_INC(drop_inc),
		.I_MAC_RDATA(mac_rd), .I_ROM_RDATA(rom_rd), .O_MAC_CMD(mac_cmd), .O_MAC_WDATA(mac_wd),
		.O_MAC_CMD_WR(mac_wr), .O_ROM_CMD(rom_cmd), .O_ROM_WDATA(rom_wd), .O_ROM_CMD_WR(rom_wr),
		.O_RX_CFG(), .O_TX_CFG(), .O_HARDWARE_CONFIG(hardware_config), .O_IRQ_CFG(irq_cfg), .O_INT_EN(int_en),
		.O_FIFO_LVL(),
		.O_GPIO_CFG(), .O_TIMER_CONFIG(), .O_FLOW_CONTROL_CONFIG(), .O_POWER_MGMT_CONTROL(), .O_SWAP());
	hcr_queue_model model (
		.i_clk(clk), .i_rxs_pop(rxs_pop), .i_rxd_pop(rxd_pop), .i_txs_pop(txs_pop),
		.i_txd_push(txd_push), .i_txd_data(txd_d), .o_rxs_data(rxs_d), .o_rxs_valid(rxs_v),
		.o_rxd_data(rxd_d), .o_txs_data(txs_d), .o_txs_valid(txs_v));
	// ====================================
	// Bus tasks: halves go low then high, back to back
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr32(input logic [7:0] a, input logic [31:0] v);
		@(negedge clk);
		wr = 1'b1;
		addr = a[7:1];
		wdata = v[15:0];
		@(negedge clk);
		addr = a[7:1] | 7'h01;
		wdata = v[31:16];
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd32(input logic [7:0] a, output logic [31:0] v);
		@(negedge clk);
		rd = 1'b1;
		addr = a[7:1];
		@(negedge clk);
		v[15:0] = rdata;
		addr = a[7:1] | 7'h01;
		@(negedge clk);
		v[31:16] = rdata;
		rd = 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd32(a, v);
		chk(v, exp);
	endtask
	task automatic complete_run;
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			complete_run;
		end
	end
	// ====================================
	// Scenarios
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 14; i++)
			rc(rst_tab[i][39:32], rst_tab[i][31:0]);
		wr32(8'h5c, 32'h1234_5678);
		rc(8'h5c, 32'h1234_5678);
		chk(int_en, 32'h1234_5678);
		wr32(8'h64, 32'h0);
		rc(8'h64, 32'h8765_4321);
		rc(8'h20, 32'h0);
		// Reserved words are only ever read, never written
		rd32(8'h60, d);
		wr32(8'h54, 32'h0000_0111);
		wr32(8'h74, 32'h0005_0001);
		repeat (2) @(negedge clk);
		rd32(8'h54, d);
		chk(d & 32'h0000_0111, 32'h0000_0011);
		chk(irq_cfg, 32'h0000_0011);
		chk(hardware_config, 32'h0005_0000);
		chk(int_en, 32'h0);
		rc(8'h5c, 32'h0);
		link_dn = 1'b1;
		@(negedge clk) link_dn = 1'b0;
		rc(8'h84, 32'h1);
		rc(8'h84, 32'h0);
		for (int q = 0; q < 2; q++) begin
			b = q ? 8'h48 : 8'h40;
			e = q ? 32'hc300_0000 : 32'ha500_0000;
			rc(b + 8'h04, e);
			rc(b, e);
			rc(b + 8'h04, e + 1);
			rc(b, e + 1);
			rd32(b, d);
		end
		chk(model.rxs_ptr, 32'h2);
		chk(model.txs_ptr, 32'h2);
		for (int i = 0; i < 8; i++) rc({i[5:0], 2'b00}, 32'hd000_0000 + 32'(i));
		for (int i = 0; i < 8; i++) wr32(8'h20 + {i[5:0], 2'b00}, 32'h7100_0000 + 32'(i * 3));
		repeat (2) @(negedge clk);
		for (int i = 0; i < 8; i++) chk(model.txd_log[i], 32'h7100_0000 + 32'(i * 3));
		chk(model.txd_cnt, 32'h8);
		int_ev = 32'h8;
		@(negedge clk);
		int_ev = 32'h0;
		wr32(8'h58, 32'h0);
		rd32(8'h58, d);
		chk(d & 32'h8, 32'h8);
		wr32(8'h58, 32'h8);
		rd32(8'h58, d);
		chk(d & 32'h8, 32'h0);
		repeat (3) begin
			@(negedge clk) drop_inc = 1'b1;
			@(negedge clk) drop_inc = 1'b0;
		end
		rc(8'ha0, 32'h3);
		wr32(8'ha4, 32'h8000_0012);
		chk(mac_wr, 32'h1);
		chk(mac_cmd, 32'h8000_0012);
		wr32(8'ha8, 32'h5a5a_0f0f);
		chk(mac_wd, 32'h5a5a_0f0f);
		rc(8'ha8, mac_rd);
		wr32(8'hb0, 32'h8000_0034);
		chk(rom_wr, 32'h1);
		chk(rom_cmd, 32'h8000_0034);
		wr32(8'hb4, 32'h0f0f_5a5a);
		chk(rom_wd, 32'h0f0f_5a5a);
		rc(8'hb4, rom_rd);
		complete_run;
	end
endmodule
